// *** design/dtio_pkg.sv ***
// shared constants and types for the drive terminal io logic
package dtio_pkg;
  localparam int          DTIO_NUM_IN     = 6;
  localparam int          DTIO_NUM_FUNC   = 9;
  localparam logic [7:0]  DTIO_IN_QUICK   = 8'h34;   // input function code 52
  localparam logic [7:0]  DTIO_OUT_RUN    = 8'h00;
  localparam logic [7:0]  DTIO_OUT_ALARM  = 8'h05;
  localparam logic [1:0]  DTIO_QS_TERM    = 2'h0;
  localparam logic [1:0]  DTIO_QS_INT     = 2'h1;
  localparam logic [1:0]  DTIO_POL_NO     = 2'h0;
  localparam logic [1:0]  DTIO_POL_NC     = 2'h1;
  // register byte offsets
  localparam logic [7:0]  DTIO_A_INSEL0   = 8'h00;   // input selectors at 0x00..0x14
  localparam logic [7:0]  DTIO_A_OC11     = 8'h18;
  localparam logic [7:0]  DTIO_A_OC12     = 8'h1c;
  localparam logic [7:0]  DTIO_A_RELAY    = 8'h20;
  localparam logic [7:0]  DTIO_A_RELPOL   = 8'h24;
  localparam logic [7:0]  DTIO_A_QSSEL    = 8'h28;
  localparam logic [7:0]  DTIO_A_CTRL     = 8'h2c;
  localparam logic [7:0]  DTIO_A_STATUS   = 8'h30;
  localparam logic [7:0]  DTIO_A_IRQ_ST   = 8'h34;
  localparam logic [7:0]  DTIO_A_IRQ_CLR  = 8'h38;
  localparam logic [7:0]  DTIO_A_IRQ_EN   = 8'h3c;
  localparam logic [7:0]  DTIO_A_PEDIT    = 8'h40;
  // reset values
  localparam logic [7:0]  DTIO_RST_INSEL  = 8'hff;
  localparam logic [7:0]  DTIO_RST_OC11   = 8'h00;
  localparam logic [7:0]  DTIO_RST_OC12   = 8'h01;
  localparam logic [7:0]  DTIO_RST_RELAY  = 8'h05;
  localparam logic [1:0]  DTIO_RST_RELPOL = 2'h1;
  localparam logic [1:0]  DTIO_RST_QSSEL  = 2'h0;
  // interrupt bit positions
  localparam int          DTIO_EV_QS_ON   = 0;
  localparam int          DTIO_EV_QS_OFF  = 1;
  localparam int          DTIO_EV_REJECT  = 2;
  localparam int          DTIO_NUM_EV     = 3;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } dtio_req_s;

  typedef enum logic [2:0] {
    DTIO_ST_STOP = 3'b001,
    DTIO_ST_RUN  = 3'b010,
    DTIO_ST_HOLD = 3'b100
  } dtio_mode_e;
endpackage : dtio_pkg

// *** design/dtio_outsel.sv ***
// output function selector with optional inversion for one output
`timescale 1ns/1ns
`default_nettype none
module dtio_outsel
  import dtio_pkg::*;
#(
  parameter int NF = DTIO_NUM_FUNC
)(
  // inputs
  input  wire logic [NF-1:0] func_vec,
  input  wire logic [7:0]    code,
  input  wire logic          invert,
  // result
  output logic               level
);
  logic sig;
  always_comb
  begin
    sig = 1'b0;
    if (code < 8'(NF))
      sig = func_vec[code[3:0]];
    level = sig ^ invert;
  end
endmodule : dtio_outsel
`default_nettype wire

// *** design/dtio_top.sv ***
// drive terminal io logic: quick start input and output routing
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - quick start asserted keeps run mode even with motor stopped
// - input code 52 is quick start; output stays energized at rest
// - quick start off: output de-energized in stop mode
// - quick start may sit on any of six input terminals
// - select 01 forces quick start internally; terminal used only at 00
// - run lamp lit continuously while quick start active
// - quick start active: only run-editable parameters accepted
// - output functions routed independently to two collectors and relay
// - relay defaults to alarm, reassignable to any output function
// - relay selector accepts any of nine output functions
// - polarity 00 coil off when signal off; 01 coil on when off
// - defaults: relay code 05 and polarity 01
// - relay code 00 routes the run-mode signal
// - alarm still assignable to terminal 11 or 12
module dtio_top
  import dtio_pkg::*;
#(
  parameter int NIN = DTIO_NUM_IN,
  parameter int NF  = DTIO_NUM_FUNC
)(
  // clock and reset
  input  wire logic          CLOCK,
  input  wire logic          RST,
  // ahb-lite slave
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic [31:0]        HRDATA,
  output logic               HREADYOUT,
  output logic               HRESP,
  // terminals and drive status
  input  wire logic [NIN-1:0] IN_TERM,
  input  wire logic          RUN_CMD,
  input  wire logic [NF-1:0] OUT_FUNC,
  output logic               DRIVE_ENERGIZE,
  output logic               RUN_MODE,
  output logic               RUN_LAMP,
  output logic               QUICK_ACTIVE,
  output logic               OC11_ON,
  output logic               OC12_ON,
  output logic               RELAY_COIL,
  output logic               IRQ
);
  logic [7:0]         insel_q [NIN];
  logic [7:0]         oc11_q;
  logic [7:0]         oc12_q;
  logic [7:0]         relay_q;
  logic [1:0]         relpol_q;
  logic [1:0]         qssel_q;
  logic [DTIO_NUM_EV-1:0] irq_st_q;
  logic [DTIO_NUM_EV-1:0] irq_en_q;
  logic [31:0]        pedit_q;
  logic [31:0]        runedit_mask_q;
  dtio_req_s          req_q;
  dtio_mode_e         mode_q;
  logic               qs_q;
  logic [NIN-1:0]     qs_hit;
  logic               qs_term;
  logic               qs_now;
  logic [NF-1:0]      func_vec;
  logic               lvl11;
  logic               lvl12;
  logic               lvlrel;
  logic               wr_go;
  logic               ctrl_wr;
  logic               reject;
  logic               pedit_ok;
  logic [31:0]        rd_d;
  logic [DTIO_NUM_EV-1:0] ev;

  // terminal decode, one comparator per input
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_in
      assign qs_hit[gi] = IN_TERM[gi] && (insel_q[gi] == DTIO_IN_QUICK);
    end
  endgenerate
  assign qs_term = |qs_hit;
  // internal enable overrides and masks the terminal
  always_comb
  begin
    case (qssel_q)
      DTIO_QS_INT:  qs_now = 1'b1;
      DTIO_QS_TERM: qs_now = qs_term;
      default:      qs_now = 1'b0;
    endcase
  end

  // ahb-lite address phase capture
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      req_q <= '0;
    else if (HREADY)
      req_q <= '{sel: HSEL && HTRANS[1], write: HWRITE, addr: HADDR[7:0]};
  end
  assign wr_go = req_q.sel && req_q.write;

  // parameter edit register: run-editable bits given by a mask
  assign ctrl_wr  = wr_go && (req_q.addr == DTIO_A_PEDIT);
  assign pedit_ok = (mode_q == DTIO_ST_STOP) && !qs_q;
  assign reject   = ctrl_wr && !pedit_ok && |(HWDATA & ~runedit_mask_q);
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      pedit_q <= '0;
    else if (ctrl_wr && !reject)
      pedit_q <= HWDATA;
  end

  // configuration registers
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      for (int i = 0; i < NIN; i++)
        insel_q[i] <= DTIO_RST_INSEL;
      oc11_q         <= DTIO_RST_OC11;
      oc12_q         <= DTIO_RST_OC12;
      relay_q        <= DTIO_RST_RELAY;
      relpol_q       <= DTIO_RST_RELPOL;
      qssel_q        <= DTIO_RST_QSSEL;
      runedit_mask_q <= '0;
      irq_en_q       <= '0;
    end
    else if (wr_go)
    begin
      for (int i = 0; i < NIN; i++)
        if (req_q.addr == DTIO_A_INSEL0 + 8'(4 * i))
          insel_q[i] <= HWDATA[7:0];
      case (req_q.addr)
        DTIO_A_OC11:   oc11_q <= HWDATA[7:0];
        DTIO_A_OC12:   oc12_q <= HWDATA[7:0];
        DTIO_A_RELAY:  relay_q <= HWDATA[7:0];
        DTIO_A_RELPOL: relpol_q <= HWDATA[1:0];
        DTIO_A_QSSEL:  qssel_q <= HWDATA[1:0];
        DTIO_A_CTRL:   runedit_mask_q <= HWDATA;
        DTIO_A_IRQ_EN: irq_en_q <= HWDATA[DTIO_NUM_EV-1:0];
        default:       ;
      endcase
    end
  end

  // drive mode machine
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      mode_q <= DTIO_ST_STOP;
      qs_q   <= 1'b0;
    end
    else
    begin
      qs_q <= qs_now;
      case (mode_q)
        DTIO_ST_STOP:
        begin
          if (RUN_CMD)
            mode_q <= DTIO_ST_RUN;
          else if (qs_now)
            mode_q <= DTIO_ST_HOLD;
        end
        DTIO_ST_RUN:
        begin
          if (!RUN_CMD)
            mode_q <= qs_now ? DTIO_ST_HOLD : DTIO_ST_STOP;
        end
        DTIO_ST_HOLD:
        begin
          if (RUN_CMD)
            mode_q <= DTIO_ST_RUN;
          else if (!qs_now)
            mode_q <= DTIO_ST_STOP;
        end
        default:      mode_q <= DTIO_ST_STOP;
      endcase
    end
  end

  // output functions: run-mode signal sits at code 00
  always_comb
  begin
    func_vec = OUT_FUNC;
    func_vec[DTIO_OUT_RUN[3:0]] = (mode_q != DTIO_ST_STOP);
  end

  dtio_outsel #(.NF(NF)) u_oc11 (
    .func_vec (func_vec),
    .code     (oc11_q),
    .invert   (1'b0),
    .level    (lvl11)
  );
  dtio_outsel #(.NF(NF)) u_oc12 (
    .func_vec (func_vec),
    .code     (oc12_q),
    .invert   (1'b0),
    .level    (lvl12)
  );
  // polarity 01 energizes the coil while the signal is off
  dtio_outsel #(.NF(NF)) u_rel (
    .func_vec (func_vec),
    .code     (relay_q),
    .invert   (relpol_q == DTIO_POL_NC),
    .level    (lvlrel)
  );

  // registered outputs
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      DRIVE_ENERGIZE <= 1'b0;
      RUN_MODE       <= 1'b0;
      RUN_LAMP       <= 1'b0;
      QUICK_ACTIVE   <= 1'b0;
      OC11_ON        <= 1'b0;
      OC12_ON        <= 1'b0;
      RELAY_COIL     <= 1'b0;
    end
    else
    begin
      DRIVE_ENERGIZE <= (mode_q != DTIO_ST_STOP);
      RUN_MODE       <= (mode_q != DTIO_ST_STOP);
      RUN_LAMP       <= (mode_q != DTIO_ST_STOP) || qs_q;
      QUICK_ACTIVE   <= qs_q;
      OC11_ON        <= lvl11;
      OC12_ON        <= lvl12;
      RELAY_COIL     <= lvlrel;
    end
  end

  // interrupt status: set wins over clear
  assign ev[DTIO_EV_QS_ON]  = qs_now && !qs_q;
  assign ev[DTIO_EV_QS_OFF] = !qs_now && qs_q;
  assign ev[DTIO_EV_REJECT] = reject;
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      irq_st_q <= '0;
    else if (wr_go && req_q.addr == DTIO_A_IRQ_CLR)
      irq_st_q <= (irq_st_q & ~HWDATA[DTIO_NUM_EV-1:0]) | ev;
    else
      irq_st_q <= irq_st_q | ev;
  end
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_st_q & irq_en_q);
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb
  begin
    rd_d = '0;
    for (int i = 0; i < NIN; i++)
      if (HADDR[7:0] == DTIO_A_INSEL0 + 8'(4 * i))
        rd_d = {24'h0, insel_q[i]};
    case (HADDR[7:0])
      DTIO_A_OC11:   rd_d = {24'h0, oc11_q};
      DTIO_A_OC12:   rd_d = {24'h0, oc12_q};
      DTIO_A_RELAY:  rd_d = {24'h0, relay_q};
      DTIO_A_RELPOL: rd_d = {30'h0, relpol_q};
      DTIO_A_QSSEL:  rd_d = {30'h0, qssel_q};
      DTIO_A_CTRL:   rd_d = runedit_mask_q;
      DTIO_A_STATUS: rd_d = {25'h0, qs_q, qs_term, mode_q, RELAY_COIL, OC12_ON};
      DTIO_A_IRQ_ST: rd_d = {29'h0, irq_st_q};
      DTIO_A_IRQ_EN: rd_d = {29'h0, irq_en_q};
      DTIO_A_PEDIT:  rd_d = pedit_q;
      default:       ;
    endcase
  end
  // zero wait: read data latched at address phase, shown in data phase
  // limitation: a read right behind a write to that register sees the old value
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (HREADY && HSEL && HTRANS[1] && !HWRITE)
        HRDATA <= rd_d;
    end
  end
endmodule : dtio_top
`default_nettype wire

// *** testbench/dtio_checker.sv ***
// port-level assertions for the drive terminal io logic
`timescale 1ns/1ns
`default_nettype none
module dtio_checker (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // observed
  input wire logic RUN_CMD,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic DRIVE_ENERGIZE,
  input wire logic RUN_MODE,
  input wire logic RUN_LAMP,
  input wire logic QUICK_ACTIVE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  AST_QS_RUN: assert property (QUICK_ACTIVE |-> RUN_MODE)
    else $error("quick start without run mode");
  AST_QS_ENERGIZE: assert property (QUICK_ACTIVE |-> DRIVE_ENERGIZE)
    else $error("quick start without energized output");
  AST_STOP_OFF: assert property (!RUN_MODE |-> !DRIVE_ENERGIZE)
    else $error("output energized in stop mode");
  AST_QS_LAMP: assert property (QUICK_ACTIVE |-> RUN_LAMP)
    else $error("run lamp dark during quick start");
  AST_IDLE_STOP: assert property (!RUN_CMD [*3] ##0 !QUICK_ACTIVE |-> !RUN_MODE)
    else $error("run mode with no run command and no quick start");
  AST_QS_FALL: assert property ($fell(QUICK_ACTIVE) && !$past(RUN_CMD, 2)
    |-> !RUN_MODE && !DRIVE_ENERGIZE)
    else $error("output not released when quick start dropped");
  AST_RUN_FOLLOW: assert property (RUN_CMD [*3] |-> RUN_MODE ##1 RUN_MODE)
    else $error("run command not followed by run mode");
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  COV_QS: cover property ($rose(QUICK_ACTIVE));
  COV_QS_END: cover property ($fell(QUICK_ACTIVE));
  COV_RUN: cover property (RUN_CMD ##2 RUN_MODE);
endmodule : dtio_checker
bind dtio_top dtio_checker u_chk (.CLOCK(CLOCK), .RST(RST), .RUN_CMD(RUN_CMD),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .DRIVE_ENERGIZE(DRIVE_ENERGIZE),
  .RUN_MODE(RUN_MODE), .RUN_LAMP(RUN_LAMP), .QUICK_ACTIVE(QUICK_ACTIVE));
`default_nettype wire

// *** testbench/dtio_ctrl_model.sv ***
// external controller driving the input terminals and output function lines
`timescale 1ns/1ns
`default_nettype none
module dtio_ctrl_model (
  // clock
  input  wire logic       clk,
  // commands from the bench
  input  wire logic [5:0] term,
  input  wire logic       run,
  input  wire logic [8:0] func,
  input  wire logic       edit,
  // terminals
  output logic [5:0]      in_term,
  output logic            run_cmd,
  output logic [8:0]      out_func
);
  // editing needs stop mode, so both levels drop first
  always_ff @(posedge clk)
  begin
    in_term  <= edit ? 6'h00 : term;
    run_cmd  <= edit ? 1'b0 : run;
    out_func <= func;
  end
endmodule : dtio_ctrl_model
`default_nettype wire

// *** testbench/dtio_tb_top.sv ***
// self-checking bench for the drive terminal io logic
`timescale 1ns/1ns
`default_nettype none
module dtio_tb_top;
  import dtio_pkg::*;
  logic CLOCK, RST, HSEL, HWRITE, edit, run, QA, RM, DE, RL, O11, O12, RC, IRQ, RUN_CMD;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [5:0] term, IN_TERM;
  logic [8:0] func, OUT_FUNC;
  logic hready;
  int mismatches, total_checks;
  initial begin CLOCK = 0; forever #10 CLOCK = ~CLOCK; end
  dtio_ctrl_model u_ctl (.clk(CLOCK), .term(term), .run(run), .func(func), .edit(edit),
    .in_term(IN_TERM), .run_cmd(RUN_CMD), .out_func(OUT_FUNC));
  dtio_top DUT (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(hready), .HRDATA(HRDATA),
    .HREADYOUT(hready), .HRESP(), .IN_TERM(IN_TERM), .RUN_CMD(RUN_CMD), .OUT_FUNC(OUT_FUNC),
    .DRIVE_ENERGIZE(DE), .RUN_MODE(RM), .RUN_LAMP(RL), .QUICK_ACTIVE(QA),
    .OC11_ON(O11), .OC12_ON(O12), .RELAY_COIL(RC), .IRQ(IRQ));
  task automatic tick(input int n); repeat (n) @(posedge CLOCK); endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single-word transfer; waits on the slave's ready each phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    HSEL <= 1'b1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= {24'h0, a};
    do @(posedge CLOCK); while (hready !== 1'b1);
    HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
    do @(posedge CLOCK); while (hready !== 1'b1);
    rd = HRDATA;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic t_reset;
    rdc(DTIO_A_INSEL0, 32'(DTIO_RST_INSEL));
    rdc(DTIO_A_OC11, 32'(DTIO_RST_OC11));
    rdc(DTIO_A_OC12, 32'(DTIO_RST_OC12));
    rdc(DTIO_A_RELAY, 32'h5);
    rdc(DTIO_A_RELPOL, 32'h1);
    rdc(DTIO_A_QSSEL, 32'h0);
    chk(RC, 1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_quick;
    for (int k = 0; k < 6; k++)
    begin
      wr(DTIO_A_INSEL0 + 8'(4 * k), 32'(DTIO_IN_QUICK));
      term <= 6'(1 << k);
      tick(4);
      chk({QA, RM, DE, RL}, 4'hf);
      term <= 6'h00;
      tick(4);
      chk({QA, RM, DE}, 3'h0);
      wr(DTIO_A_INSEL0 + 8'(4 * k), 32'(DTIO_RST_INSEL));
    end
    wr(DTIO_A_QSSEL, 32'h1);
    tick(4);
    chk({QA, DE}, 2'h3);
    wr(DTIO_A_QSSEL, 32'h0);
    tick(4);
    chk(QA, 0);
    $display("test quick start done");
  endtask : t_quick
  task automatic t_edit;
    wr(DTIO_A_IRQ_CLR, 32'h7);
    wr(DTIO_A_CTRL, 32'h0f);
    wr(DTIO_A_PEDIT, 32'h11);
    wr(DTIO_A_INSEL0, 32'(DTIO_IN_QUICK));
    term <= 6'h01;
    run <= 1'b1;
    tick(4);
    wr(DTIO_A_PEDIT, 32'hf0);
    rdc(DTIO_A_PEDIT, 32'h11);
    rdc(DTIO_A_IRQ_ST, 32'h5);
    wr(DTIO_A_IRQ_EN, 32'h4);
    tick(3);
    chk(IRQ, 1);
    wr(DTIO_A_IRQ_EN, 32'h0);
    tick(3);
    chk(IRQ, 0);
    wr(DTIO_A_IRQ_CLR, 32'h4);
    wr(DTIO_A_IRQ_EN, 32'h4);
    tick(3);
    chk(IRQ, 0);
    edit <= 1'b1;
    tick(4);
    wr(DTIO_A_PEDIT, 32'hf0);
    rdc(DTIO_A_PEDIT, 32'hf0);
    {edit, run, term} <= '0;
    wr(DTIO_A_INSEL0, 32'(DTIO_RST_INSEL));
    $display("test edit lock done");
  endtask : t_edit
  task automatic t_relay;
    // stopped drive, so code 0 carries a low run-mode signal
    for (int p = 0; p < 2; p++)
    begin
      wr(DTIO_A_RELPOL, 32'(p));
      for (int c = 0; c < 9; c++)
      begin
        wr(DTIO_A_RELAY, 32'(c));
        func <= 9'(1 << c);
        tick(4);
        chk(RC, 32'((c != 0) ^ p));
      end
    end
    wr(DTIO_A_OC11, 32'(DTIO_OUT_ALARM));
    wr(DTIO_A_OC12, 32'(DTIO_OUT_ALARM));
    func <= 9'h020;
    tick(4);
    chk({O11, O12}, 2'h3);
    func <= 9'h000;
    tick(4);
    chk({O11, O12}, 2'h0);
    // run-mode signal at code 00 on relay and a collector
    wr(DTIO_A_RELAY, 32'(DTIO_OUT_RUN));
    wr(DTIO_A_RELPOL, 32'h0);
    wr(DTIO_A_OC11, 32'(DTIO_OUT_RUN));
    run <= 1'b1;
    tick(4);
    chk({RC, O11}, 2'h3);
    run <= 1'b0;
    tick(4);
    chk({RC, O11}, 2'h0);
    $display("test relay done");
  endtask : t_relay
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    {RST, HSEL, HWRITE, edit, run, term, func, HTRANS} = '0;
    {HADDR, HWDATA} = '0;
    RST = 1'b1;
    tick(8);
    RST <= 1'b0;
    tick(2);
    t_reset();
    t_quick();
    t_edit();
    t_relay();
    summarize();
  end
  // the tests need a few hundred cycles
  initial
  begin
    tick(20000);
    mismatches++;
    summarize();
  end
endmodule : dtio_tb_top
`default_nettype wire
